// *** inc/eqf_consts.vh ***
// Constants for the equaliser, compander and main control block.
// Assumes an upstream I2C slave engine that delivers subaddress and data bytes.
`ifndef EQF_CONSTS_VH
`define EQF_CONSTS_VH

`define EQF_SUB_MAIN_ONE    8'h01
`define EQF_SUB_MAIN_TWO    8'h43
`define EQF_SUB_ANALOG      8'h40
`define EQF_SUB_EQ_LEFT     8'h0a
`define EQF_SUB_EQ_RIGHT    8'h11
`define EQF_SUB_COMPANDER   8'h06

`define EQF_LEN_REG         4'd1
`define EQF_LEN_STAGE       4'd15
`define EQF_LEN_COMPANDER   4'd8
`define EQF_BUF_DEPTH       15

`define EQF_STAGES          7
`define EQF_ALL_STAGES      14
`define EQF_COEFS           5
`define EQF_COEF_TOTAL      70
`define EQF_LAST_LEFT       4'd6
`define EQF_LAST_STAGE      4'd13

`define EQF_COEF_ONE        24'h100000
`define EQF_COEF_ZERO       24'h000000
`define EQF_FRAC_BITS       20

`define EQF_M1_QUICK        7
`define EQF_M1_RATIO        6
`define EQF_M1_FMT_HI       5
`define EQF_M1_FMT_LO       4
`define EQF_M1_WL_HI        1
`define EQF_M1_WL_LO        0
`define EQF_M1_RESET        8'h80
`define EQF_M2_DOWNLOAD     7
`define EQF_M2_FLAT         1
`define EQF_AN_FLAT         2
`define EQF_AN_ZERO_MASK    8'hcf

`define EQF_CMP_HDR0        8'h58
`define EQF_CMP_HDR1        8'h60
`define EQF_CMP_ENABLE_BYTE 2
`define EQF_CMP_SCALE_BYTE  5

`define EQF_SAMPLE_MAX      24'h7fffff
`define EQF_SAMPLE_MIN      24'h800000
`define EQF_STATE_MAX       32'h7fffffff
`define EQF_STATE_MIN       32'h80000000

`endif

// *** rtl/eqf_biquad.v ***
// One transposed direct form II biquad stage, purely combinational.
// Assumes the caller holds the two state words and the five 4.20 coefficients.
`timescale 1ns/1ps
`include "eqf_consts.vh"

module eqf_biquad (
    input  wire signed [23:0] x,     // Stage input sample
    input  wire signed [23:0] b0,    // Numerator coefficient 0
    input  wire signed [23:0] b1,    // Numerator coefficient 1
    input  wire signed [23:0] b2,    // Numerator coefficient 2
    input  wire signed [23:0] a1,    // Denominator coefficient 1
    input  wire signed [23:0] a2,    // Denominator coefficient 2
    input  wire signed [31:0] s1,    // First state word
    input  wire signed [31:0] s2,    // Second state word
    output reg  signed [23:0] y,     // Stage output sample, saturated
    output reg  signed [31:0] ns1,   // Next first state word
    output reg  signed [31:0] ns2    // Next second state word
);

    wire signed [47:0] pb0 = x * b0;
    wire signed [47:0] pb1 = x * b1;
    wire signed [47:0] pb2 = x * b2;
    wire signed [47:0] pa1 = y * a1;
    wire signed [47:0] pa2 = y * a2;
    reg  signed [33:0] acc_y;
    reg  signed [33:0] acc_1;

    // The leading denominator term is a fixed one, so no divide is needed.
    always @* begin
        acc_y = {{6{pb0[47]}}, pb0[47:`EQF_FRAC_BITS]} + {{2{s1[31]}}, s1};
        if (acc_y > $signed({{10{1'b0}}, `EQF_SAMPLE_MAX}))
            y = `EQF_SAMPLE_MAX;
        else if (acc_y < $signed({{10{1'b1}}, `EQF_SAMPLE_MIN}))
            y = `EQF_SAMPLE_MIN;
        else
            y = acc_y[23:0];
    end

    // The state update reads y through pa1 and pa2, so it sits in its own process.
    always @* begin
        acc_1 = {{6{pb1[47]}}, pb1[47:`EQF_FRAC_BITS]}
              - {{6{pa1[47]}}, pa1[47:`EQF_FRAC_BITS]}
              + {{2{s2[31]}}, s2};
        if (acc_1 > $signed({2'b00, `EQF_STATE_MAX}))
            ns1 = `EQF_STATE_MAX;
        else if (acc_1 < $signed({2'b11, `EQF_STATE_MIN}))
            ns1 = `EQF_STATE_MIN;
        else
            ns1 = acc_1[31:0];
        ns2 = {{4{pb2[47]}}, pb2[47:`EQF_FRAC_BITS]}
            - {{4{pa2[47]}}, pa2[47:`EQF_FRAC_BITS]};
    end

endmodule

// *** rtl/eqf_top.v ***
// Seven-stage stereo equaliser, flat bypass, compander, saturation and main control.
// Assumes an I2C slave engine on ref_clk delivering subaddress, data bytes and stop.
//
// Operation
// - Compander scales samples after volume stage.
// - Overflowing samples clamp at full scale.
// - Flat pin high bypasses every biquad.
// - Flat pin low restores previous equalisation.
// - Tone controls remain active in flat.
// - Analog control bit 2 also selects flat.
// - Main one bit 7: quick load, default one.
// - Main one bit 6: bit clock ratio.
// - Main one bits 5-4: serial format.
// - Main one bits 1-0: word length.
// - Main two bit 7: tone download, reset zero.
// - Main two bit 1: flat, reset zero.
// - Main two bits 6-2 read zero.
// - Main two bit 0 reads zero.
// - Seven biquads per channel, own coefficients.
// - Leading denominator coefficient fixed at one.
// - Coefficients are three bytes, MSB first.
// - Each stage has its own subaddress.
// - A rising edge on any general purpose input reloads the reset coefficients (b0 one, others zero).
`timescale 1ns/1ps
`include "eqf_consts.vh"

module eqf_top (
    input  wire        ref_clk,                // 100 MHz system clock
    input  wire        nrst,                   // Asynchronous reset, active low
    input  wire [7:0]  reg_sub,                // Subaddress from the I2C engine
    input  wire        reg_start,              // Pulse: subaddress byte received
    input  wire [7:0]  reg_wdata,              // Data byte from the I2C engine
    input  wire        reg_wvalid,             // Pulse: data byte received
    input  wire        reg_stop,               // Pulse: write transaction ended
    output reg  [7:0]  reg_rdata,              // Read value of the addressed register
    input  wire        flat_eq_pin,            // Flat equalisation pin, asynchronous
    input  wire [3:0]  general_purpose_inputs, // Preset load pins, asynchronous
    input  wire [23:0] sample_l,               // Left sample after volume stage
    input  wire [23:0] sample_r,               // Right sample after volume stage
    input  wire        sample_valid,           // Pulse: new stereo sample pair
    output reg  [23:0] out_l,                  // Processed left sample
    output reg  [23:0] out_r,                  // Processed right sample
    output reg         out_valid,              // Pulse: processed pair ready
    output reg         quick_load_select,      // Fast load mode selected
    output reg         bit_clock_ratio,        // 0: 32x, 1: 64x sample rate
    output reg  [1:0]  serial_format,          // Serial audio format code
    output reg  [1:0]  word_length,            // Serial word length code
    output reg         tone_download,          // Bass and treble download request
    output reg         flat_active             // Equaliser currently bypassed
);

    localparam ST_IDLE = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_OUT  = 3'b100;
    localparam [7:0] M1_RESET = `EQF_M1_RESET;

    integer i;
    integer j;

    // Synchronisers for the asynchronous pins.
    reg        flat_meta;
    reg        flat_sync;
    reg [3:0]  gpi_meta;
    reg [3:0]  gpi_sync;
    reg [3:0]  gpi_prev;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flat_meta <= 1'b0;
            flat_sync <= 1'b0;
            gpi_meta  <= 4'h0;
            gpi_sync  <= 4'h0;
            gpi_prev  <= 4'h0;
        end else begin
            flat_meta <= flat_eq_pin;
            flat_sync <= flat_meta;
            gpi_meta  <= general_purpose_inputs;
            gpi_sync  <= gpi_meta;
            gpi_prev  <= gpi_sync;
        end
    end

    wire gpi_load = |(gpi_sync & ~gpi_prev);

    // Write collection: bytes are buffered and committed only on a complete count.
    reg [7:0]  cur_sub;
    reg [3:0]  byte_cnt;
    reg        overrun;
    reg [7:0]  wbuf [0:`EQF_BUF_DEPTH-1];
    reg [3:0]  need_len;
    reg        is_stage;
    reg [3:0]  stage_sel;
    wire [7:0] stage_off = cur_sub - `EQF_SUB_EQ_LEFT;

    always @* begin
        is_stage  = 1'b0;
        stage_sel = 4'h0;
        need_len  = `EQF_LEN_REG;
        if (cur_sub >= `EQF_SUB_EQ_LEFT && cur_sub < `EQF_SUB_EQ_RIGHT + `EQF_STAGES) begin
            is_stage  = 1'b1;
            stage_sel = stage_off[3:0];
            need_len  = `EQF_LEN_STAGE;
        end else if (cur_sub == `EQF_SUB_COMPANDER) begin
            need_len  = `EQF_LEN_COMPANDER;
        end
    end

    wire commit = reg_stop && !overrun && byte_cnt == need_len;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cur_sub  <= 8'h00;
            byte_cnt <= 4'h0;
            overrun  <= 1'b0;
            for (i = 0; i < `EQF_BUF_DEPTH; i = i + 1)
                wbuf[i] <= 8'h00;
        end else if (reg_start) begin
            cur_sub  <= reg_sub;
            byte_cnt <= 4'h0;
            overrun  <= 1'b0;
        end else if (reg_wvalid) begin
            if (byte_cnt == `EQF_LEN_STAGE)
                overrun <= 1'b1;
            else begin
                wbuf[byte_cnt] <= reg_wdata;
                byte_cnt       <= byte_cnt + 4'h1;
            end
        end else if (reg_stop) begin
            byte_cnt <= 4'h0;
        end
    end

    // Control registers.
    reg [7:0] analog_ctrl;
    reg       cmp_enable;
    reg [23:0] cmp_scale;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            quick_load_select <= M1_RESET[`EQF_M1_QUICK];
            bit_clock_ratio   <= 1'b0;
            serial_format     <= 2'b00;
            word_length       <= 2'b00;
            tone_download     <= 1'b0;
            analog_ctrl       <= 8'h00;
            cmp_enable        <= 1'b0;
            cmp_scale         <= `EQF_COEF_ONE;
        end else if (commit) begin
            case (cur_sub)
                `EQF_SUB_MAIN_ONE: begin
                    quick_load_select <= wbuf[0][`EQF_M1_QUICK];
                    bit_clock_ratio   <= wbuf[0][`EQF_M1_RATIO];
                    serial_format     <= wbuf[0][`EQF_M1_FMT_HI:`EQF_M1_FMT_LO];
                    word_length       <= wbuf[0][`EQF_M1_WL_HI:`EQF_M1_WL_LO];
                end
                `EQF_SUB_MAIN_TWO: begin
                    tone_download <= wbuf[0][`EQF_M2_DOWNLOAD];
                end
                `EQF_SUB_ANALOG: begin
                    analog_ctrl <= wbuf[0] & `EQF_AN_ZERO_MASK;
                end
                `EQF_SUB_COMPANDER: begin
                    // The fixed header bytes are trusted to the controller.
                    cmp_enable <= wbuf[`EQF_CMP_ENABLE_BYTE][0];
                    cmp_scale  <= {wbuf[`EQF_CMP_SCALE_BYTE],
                                   wbuf[`EQF_CMP_SCALE_BYTE+1],
                                   wbuf[`EQF_CMP_SCALE_BYTE+2]};
                end
                default: begin
                end
            endcase
        end
    end

    reg flat_reg;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            flat_reg <= 1'b0;
        else if (commit && cur_sub == `EQF_SUB_MAIN_TWO)
            flat_reg <= wbuf[0][`EQF_M2_FLAT];
    end

    wire flat_now = flat_sync | analog_ctrl[`EQF_AN_FLAT] | flat_reg;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            flat_active <= 1'b0;
        else
            flat_active <= flat_now;
    end

    // Read-back of the addressed control register.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else begin
            case (cur_sub)
                `EQF_SUB_MAIN_ONE:
                    reg_rdata <= {quick_load_select, bit_clock_ratio, serial_format,
                                  2'b00, word_length};
                `EQF_SUB_MAIN_TWO:
                    reg_rdata <= {tone_download, 5'b00000, flat_reg, 1'b0};
                `EQF_SUB_ANALOG:
                    reg_rdata <= analog_ctrl;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // Coefficient memory: stage s, coefficient k at entry 5*s+k, MSB byte first.
    reg [23:0] coef [0:`EQF_COEF_TOTAL-1];

    genvar g;
    generate
        for (g = 0; g < `EQF_COEF_TOTAL; g = g + 1) begin : g_coef
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst)
                    coef[g] <= (g % `EQF_COEFS == 0) ? `EQF_COEF_ONE : `EQF_COEF_ZERO;
                else if (gpi_load)
                    coef[g] <= (g % `EQF_COEFS == 0) ? `EQF_COEF_ONE : `EQF_COEF_ZERO;
                else if (commit && is_stage && stage_sel == g / `EQF_COEFS)
                    coef[g] <= {wbuf[3*(g%`EQF_COEFS)],
                                wbuf[3*(g%`EQF_COEFS)+1],
                                wbuf[3*(g%`EQF_COEFS)+2]};
            end
        end
    endgenerate

    // Sample sequencer: one biquad stage per cycle, left stages then right.
    reg [2:0]  state;
    reg [3:0]  stage;
    reg [23:0] cur;
    reg [23:0] hold_r;
    reg [23:0] res_l;
    reg [31:0] st1 [0:`EQF_ALL_STAGES-1];
    reg [31:0] st2 [0:`EQF_ALL_STAGES-1];

    wire [6:0]  cbase = {3'b000, stage} * 7'd5;
    wire [23:0] bq_y;
    wire [31:0] bq_s1;
    wire [31:0] bq_s2;

    eqf_biquad u_biquad (
        .x   (cur),
        .b0  (coef[cbase]),
        .b1  (coef[cbase+7'd1]),
        .b2  (coef[cbase+7'd2]),
        .a1  (coef[cbase+7'd3]),
        .a2  (coef[cbase+7'd4]),
        .s1  (st1[stage]),
        .s2  (st2[stage]),
        .y   (bq_y),
        .ns1 (bq_s1),
        .ns2 (bq_s2)
    );

    // Flat mode leaves coefficients and state untouched, so leaving it resumes
    // the previous response without any reload. Tone stages lie outside this path.
    wire [23:0] stage_out = flat_now ? cur : bq_y;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state  <= ST_IDLE;
            stage  <= 4'h0;
            cur    <= 24'h000000;
            hold_r <= 24'h000000;
            res_l  <= 24'h000000;
            for (j = 0; j < `EQF_ALL_STAGES; j = j + 1) begin
                st1[j] <= 32'h00000000;
                st2[j] <= 32'h00000000;
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    if (sample_valid) begin
                        cur    <= sample_l;
                        hold_r <= sample_r;
                        stage  <= 4'h0;
                        state  <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!flat_now) begin
                        st1[stage] <= bq_s1;
                        st2[stage] <= bq_s2;
                    end
                    if (stage == `EQF_LAST_LEFT) begin
                        res_l <= stage_out;
                        cur   <= hold_r;
                    end else
                        cur   <= stage_out;
                    if (stage == `EQF_LAST_STAGE)
                        state <= ST_OUT;
                    else
                        stage <= stage + 4'h1;
                end
                ST_OUT: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Compander scaling followed by saturation.
    function [23:0] eqf_scale_sat;
        input [23:0] smp;
        input        en;
        input [23:0] scale;
        reg signed [47:0] prod;
        reg signed [27:0] sh;
        begin
            prod = $signed(smp) * $signed(scale);
            sh   = prod[47:`EQF_FRAC_BITS];
            if (!en)
                eqf_scale_sat = smp;
            else if (sh > $signed({4'h0, `EQF_SAMPLE_MAX}))
                eqf_scale_sat = `EQF_SAMPLE_MAX;
            else if (sh < $signed({4'hf, `EQF_SAMPLE_MIN}))
                eqf_scale_sat = `EQF_SAMPLE_MIN;
            else
                eqf_scale_sat = sh[23:0];
        end
    endfunction

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_l     <= 24'h000000;
            out_r     <= 24'h000000;
            out_valid <= 1'b0;
        end else if (state == ST_OUT) begin
            out_l     <= eqf_scale_sat(res_l, cmp_enable, cmp_scale);
            out_r     <= eqf_scale_sat(cur, cmp_enable, cmp_scale);
            out_valid <= 1'b1;
        end else begin
            out_valid <= 1'b0;
        end
    end

endmodule

// *** testbench/eqf_top_props.sv ***
// Port assertions for the equaliser, compander and main control block.
// Assumes register strobes and samples arrive on ref_clk as the ports describe.
`timescale 1ns/1ps
module eqf_top_props (
    input logic        ref_clk,           // Clock
    input logic        nrst,              // Reset, active low
    input logic [7:0]  reg_sub,           // Subaddress
    input logic        reg_start,         // Write opens
    input logic [7:0]  reg_wdata,         // Data byte
    input logic        reg_wvalid,        // Byte strobe
    input logic        reg_stop,          // Write ends
    input logic [7:0]  reg_rdata,         // Read value
    input logic        flat_eq_pin,       // Flat pin
    input logic        sample_valid,      // Sample strobe
    input logic [23:0] out_l,             // Left output
    input logic [23:0] out_r,             // Right output
    input logic        out_valid,         // Output strobe
    input logic        quick_load_select, // Quick load
    input logic        bit_clock_ratio,   // Bit clock ratio
    input logic [1:0]  serial_format,     // Serial format
    input logic [1:0]  word_length,       // Word length
    input logic        tone_download,     // Tone download
    input logic        flat_active        // Flat state
);
    logic [7:0] last_byte;
    logic [7:0] main_one_now;

    assign main_one_now = {quick_load_select, bit_clock_ratio, serial_format, 2'b00, word_length};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            last_byte <= 8'h00;
        end else if (reg_wvalid) begin
            last_byte <= reg_wdata;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence wr_one(logic [7:0] sub);
        (reg_start && reg_sub == sub) ##1 (reg_wvalid && !reg_start)
            ##1 (reg_stop && !reg_start && !reg_wvalid);
    endsequence

    sequence sel_hold(logic [7:0] sub);
        (reg_start && reg_sub == sub) ##1 (!reg_start) [*2];
    endsequence

    chk_reset_dflt: assert property (
        $rose(nrst) |-> main_one_now == 8'h80 && !tone_download && !flat_active)
        else $error("control outputs wrong after reset");
    chk_main_one_wr: assert property (wr_one(8'h01) |=> main_one_now == (last_byte & 8'hf3))
        else $error("main one fields differ from written byte");
    chk_main_one_rd: assert property (sel_hold(8'h01) |-> reg_rdata == $past(main_one_now))
        else $error("main one read value wrong");
    chk_tone_wr: assert property (wr_one(8'h43) |=> tone_download == last_byte[7])
        else $error("download flag differs from written byte");
    chk_flat_reg: assert property (wr_one(8'h43) ##1 last_byte[1] |=> flat_active)
        else $error("flat not entered from main two");
    chk_flat_analog: assert property (wr_one(8'h40) ##1 last_byte[2] |=> flat_active)
        else $error("flat not entered from analog control");
    chk_flat_pin: assert property (flat_eq_pin [*4] |=> flat_active)
        else $error("flat not entered from pin");
    chk_main_two_rd: assert property (sel_hold(8'h43) |-> (reg_rdata & 8'h7d) == 8'h00)
        else $error("main two read-only bits not zero");
    chk_out_pulse: assert property (out_valid |=> !out_valid [*8])
        else $error("output strobe too long or too close");
    chk_out_latency: assert property (out_valid |-> $past(sample_valid, 16))
        else $error("output strobe without sample sixteen cycles before");
    chk_out_hold: assert property (!out_valid |-> $stable(out_l) && $stable(out_r))
        else $error("output changed without strobe");
endmodule

bind eqf_top eqf_top_props u_props (.ref_clk, .nrst, .reg_sub, .reg_start, .reg_wdata,
    .reg_wvalid, .reg_stop, .reg_rdata, .flat_eq_pin, .sample_valid, .out_l, .out_r,
    .out_valid, .quick_load_select, .bit_clock_ratio, .serial_format, .word_length,
    .tone_download, .flat_active);

// *** testbench/eqf_host_model.sv ***
// Controller model that writes registers, coefficients and compander settings.
// Assumes the block takes one strobe per ref_clk cycle.
`timescale 1ns/1ps
`include "eqf_consts.vh"
module eqf_host_model (
    input  logic       ref_clk,    // Clock
    output logic [7:0] reg_sub,    // Subaddress
    output logic       reg_start,  // Write opens
    output logic [7:0] reg_wdata,  // Data byte
    output logic       reg_wvalid, // Byte strobe
    output logic       reg_stop    // Write ends
);
    logic [7:0] pay[$];
    logic       slow;

    initial begin
        reg_sub = 8'h00;
        reg_start = 1'b0;
        reg_wdata = 8'h00;
        reg_wvalid = 1'b0;
        reg_stop = 1'b0;
        slow = 1'b0;
    end

    // Idle data cycles carry inverted data so a stale byte is never mistaken for valid.
    task automatic send(input logic [7:0] sub);
        @(posedge ref_clk);
        reg_start <= 1'b1;
        reg_sub <= sub;
        while (pay.size() > 0) begin
            @(posedge ref_clk);
            reg_start <= 1'b0;
            reg_wvalid <= 1'b1;
            reg_wdata <= pay.pop_front();
            if (slow) begin
                @(posedge ref_clk);
                reg_wvalid <= 1'b0;
                reg_wdata <= ~reg_wdata;
            end
        end
        @(posedge ref_clk);
        reg_start <= 1'b0;
        reg_wvalid <= 1'b0;
        reg_stop <= 1'b1;
        reg_wdata <= ~reg_wdata;
        @(posedge ref_clk);
        reg_stop <= 1'b0;
    endtask

    task automatic coef(input logic [23:0] c);
        pay.push_back(c[23:16]);
        pay.push_back(c[15:8]);
        pay.push_back(c[7:0]);
    endtask

    task automatic stage(input logic [7:0] sub, input logic [23:0] b0);
        coef(b0);
        repeat (4) coef(24'h000000);
        send(sub);
    endtask

    task automatic compand(input logic en, input logic [23:0] scale);
        pay.push_back(`EQF_CMP_HDR0);
        pay.push_back(`EQF_CMP_HDR1);
        pay.push_back({7'h00, en});
        pay.push_back(8'h00);
        pay.push_back(8'h00);
        coef(scale);
        send(`EQF_SUB_COMPANDER);
    endtask
endmodule

// *** testbench/eq_filter_and_main_control_tb.sv ***
// Self-checking bench for the equaliser, compander and main control block.
// Assumes the host model drives register strobes; the bench drives samples and pins.
`timescale 1ns/1ps
`include "eqf_consts.vh"
module eq_filter_and_main_control_tb;
    logic        ref_clk;
    logic        nrst;
    logic [7:0]  reg_sub;
    logic        reg_start;
    logic [7:0]  reg_wdata;
    logic        reg_wvalid;
    logic        reg_stop;
    logic [7:0]  reg_rdata;
    logic        flat_eq_pin;
    logic [3:0]  general_purpose_inputs;
    logic [23:0] sample_l;
    logic [23:0] sample_r;
    logic        sample_valid;
    logic [23:0] out_l;
    logic [23:0] out_r;
    logic        out_valid;
    logic        quick_load_select;
    logic        bit_clock_ratio;
    logic [1:0]  serial_format;
    logic [1:0]  word_length;
    logic        tone_download;
    logic        flat_active;
    logic [7:0]  ctl;
    logic [7:0]  b;
    logic [23:0] x;
    logic [23:0] y;
    int          failures;
    int          tests_run;

    assign ctl = {quick_load_select, bit_clock_ratio, serial_format, word_length,
                  tone_download, flat_active};

    eqf_host_model u_host (.ref_clk, .reg_sub, .reg_start, .reg_wdata, .reg_wvalid, .reg_stop);
    eqf_top u_dut (.ref_clk, .nrst, .reg_sub, .reg_start, .reg_wdata, .reg_wvalid, .reg_stop,
        .reg_rdata, .flat_eq_pin, .general_purpose_inputs, .sample_l, .sample_r, .sample_valid,
        .out_l, .out_r, .out_valid, .quick_load_select, .bit_clock_ratio, .serial_format,
        .word_length, .tone_download, .flat_active);

    always #5 ref_clk = ~ref_clk;

    function automatic logic [23:0] gain(input logic [23:0] v, input logic [23:0] g);
        longint p;
        p = (longint'($signed(v)) * longint'($signed(g))) >>> `EQF_FRAC_BITS;
        if (p > 8388607) return `EQF_SAMPLE_MAX;
        if (p < -8388608) return `EQF_SAMPLE_MIN;
        return p[23:0];
    endfunction

    task check(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task print_verdict();
        $display("Checks run %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        u_host.pay.push_back(d);
        u_host.send(sub);
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic frame(input logic [23:0] xl, input logic [23:0] xr,
                         input logic [23:0] gl, input logic [23:0] gr);
        int n;
        n = 0;
        @(posedge ref_clk);
        sample_l <= xl;
        sample_r <= xr;
        sample_valid <= 1'b1;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        sample_l <= ~xl;
        sample_r <= ~xr;
        while (out_valid !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 40) begin
            failures++;
            $display("wrong value at %0t: no output strobe", $time);
        end
        check(out_l, gain(xl, gl));
        check(out_r, gain(xr, gr));
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        print_verdict();
    end

    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        flat_eq_pin = 1'b0;
        general_purpose_inputs = 4'h0;
        sample_l = 24'h000000;
        sample_r = 24'h000000;
        sample_valid = 1'b0;
        failures = 0;
        tests_run = 0;
        void'($urandom(32'hdd6ad220));
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        check({16'h0000, ctl}, 24'h000080);
        for (int i = 0; i < 4; i++) begin
            b = $urandom;
            b[5:4] = i[1:0];
            b[1:0] = i[1:0] ^ 2'b01;
            u_host.slow = i[0];
            wr(`EQF_SUB_MAIN_ONE, b);
            check({16'h0000, ctl}, {16'h0000, b[7:4], b[1:0], 2'b00});
            check({16'h0000, reg_rdata}, {16'h0000, b & 8'hf3});
        end
        u_host.slow = 1'b0;
        u_host.pay.push_back(8'h00);
        wr(`EQF_SUB_MAIN_ONE, 8'h00);
        check({16'h0000, reg_rdata}, {16'h0000, b & 8'hf3});
        wr(`EQF_SUB_MAIN_TWO, 8'hff);
        check({16'h0000, reg_rdata}, 24'h000082);
        check({22'h000000, tone_download, flat_active}, 24'h000003);
        wr(`EQF_SUB_MAIN_TWO, 8'h00);
        wr(`EQF_SUB_ANALOG, 8'h34);
        check({16'h0000, reg_rdata}, 24'h000004);
        check({23'h000000, flat_active}, 24'h000001);
        wr(`EQF_SUB_ANALOG, 8'h00);
        check({16'h0000, ctl}, {16'h0000, b[7:4], b[1:0], 2'b00});
        x = $urandom;
        y = $urandom;
        frame(x, y, `EQF_COEF_ONE, `EQF_COEF_ONE);
        u_host.stage(`EQF_SUB_EQ_LEFT, 24'h200000);
        u_host.stage(8'h17, 24'h400000);
        frame(x, y, 24'h200000, 24'h400000);
        frame(24'h7ff000, 24'h900000, 24'h200000, 24'h400000);
        @(posedge ref_clk);
        flat_eq_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        frame(x, y, `EQF_COEF_ONE, `EQF_COEF_ONE);
        u_host.compand(1'b1, 24'h080000);
        frame(x & 24'hfffffe, y & 24'hfffffe, 24'h080000, 24'h080000);
        u_host.compand(1'b1, 24'h400000);
        frame(24'h300000, 24'hc00000, 24'h400000, 24'h400000);
        u_host.compand(1'b0, 24'h400000);
        flat_eq_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        frame(x, y, 24'h200000, 24'h400000);
        wr(`EQF_SUB_MAIN_TWO, 8'h02);
        frame(x, y, `EQF_COEF_ONE, `EQF_COEF_ONE);
        wr(`EQF_SUB_MAIN_TWO, 8'h00);
        @(posedge ref_clk);
        general_purpose_inputs <= 4'h1 << ($urandom % 4);
        repeat (4) @(posedge ref_clk);
        general_purpose_inputs <= 4'h0;
        frame(x, y, `EQF_COEF_ONE, `EQF_COEF_ONE);
        print_verdict();
    end
endmodule
